// File: core/dopc_defs.vh
// dopc_defs.vh: register offsets, field positions, reset values for the dual dac output control
// assumes: included by core/dopc_ctrl.v only
`ifndef DOPC_DEFS_VH
`define DOPC_DEFS_VH
`define DOPC_ADDR_CTRL 8'h00
`define DOPC_ADDR_STATUS 8'h04
`define DOPC_ADDR_GPIO 8'h08
`define DOPC_ADDR_DATA0 8'h10
`define DOPC_ADDR_DATA1 8'h14
`define DOPC_ADDR_TRIM0 8'h18
`define DOPC_ADDR_TRIM1 8'h1C
`define DOPC_ADDR_OUT0 8'h20
`define DOPC_ADDR_OUT1 8'h24
`define DOPC_CTRL_LGND 0
`define DOPC_TRIM_RANGE_LSB 0
`define DOPC_TRIM_FINE_LSB 8
`define DOPC_TRIM_OFS_LSB 16
`define DOPC_GPIO_OUT_LSB 0
`define DOPC_GPIO_DIR_LSB 2
`define DOPC_GPIO_IN_LSB 4
`define DOPC_DATA_RESET 16'h0000
`define DOPC_RANGE_RESET 2'h0
`define DOPC_FINE_RESET 6'h00
`define DOPC_OFS_RESET 8'h00
`define DOPC_BIPOLAR_FLIP 16'h8000
`endif

// File: core/dopc_ctrl.v
// dopc_ctrl.v: digital control of a dual 16-bit voltage dac: clamp and amp gates,
// power-on output state, offset/gain trims, local ground option, 2-bit gpio port.
// assumes: apb master on clk, supply detector and strap pins synchronous to clk.
// Operation
// R1: supplies changing: clamp outputs, amp gate open
// R2: stable supplies plus data write releases clamp
// R3: low reset request forces clamped state
// R4: supply detector state driven on output
// R5: offset plus minus sixteen, eighth LSB steps
// R6: range select and fine trim applied
// R7: two gpio pins, independent direction each
// R8: gpio outputs written, pins read over bus
// R9: local ground option corrects channel outputs
// R10: clear low at power-up zeroes codes
// R11: code zero: 0V twos, negative full binary
// R12: load strobe low at power-up like clear
// R13: both high: clamped until valid write
// R14: two-bit range field, default zero
// R15: six-bit twos complement fine gain field
// R16: eight-bit twos complement offset field
// R17: data register write counts as valid write
`include "dopc_defs.vh"
module dopc_ctrl (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // supply and strap pins
    input wire supplyStable,
    input wire reset_request_input_n,
    input wire clear_input_n,
    input wire load_strobe_n,
    input wire coding_select,
    // ground difference per channel, signed in eighth LSB
    input wire [15:0] groundDiff0,
    input wire [15:0] groundDiff1,
    // analog control outputs
    output reg supply_monitor_output,
    output reg amp_path_gate,
    output reg clamp_gate,
    output reg [17:0] dacCode0,
    output reg [17:0] dacCode1,
    output reg [1:0] rangeSel0,
    output reg [1:0] rangeSel1,
    output reg [5:0] fineGain0,
    output reg [5:0] fineGain1,
    // gpio pins
    input wire [1:0] gpioIn,
    output reg [1:0] gpioOut,
    output reg [1:0] gpioOe
);
    localparam [2:0] ST_POWERUP = 3'b001;
    localparam [2:0] ST_CLAMPED = 3'b010;
    localparam [2:0] ST_DRIVE = 3'b100;

    reg [2:0] state;
    reg [2:0] next_state;
    reg lgndEn;
    reg [1:0] gpioDir;
    reg [1:0] gpioOutVal;
    reg [1:0] gpioPins;
    reg [15:0] dataReg [0:1];
    reg [1:0] rangeReg [0:1];
    reg [5:0] fineReg [0:1];
    reg [7:0] ofsReg [0:1];
    reg [17:0] corrected [0:1];
    wire [15:0] gdiff [0:1];
    reg dataWritten;
    reg zeroStrap;

    wire apbWrite = psel && penable && pwrite && !pready;
    wire apbRead = psel && penable && !pwrite && !pready;
    wire valid_addr = (paddr == `DOPC_ADDR_CTRL) || (paddr == `DOPC_ADDR_STATUS) ||
        (paddr == `DOPC_ADDR_GPIO) || (paddr[7:4] == 4'h1) ||
        (paddr == `DOPC_ADDR_OUT0) || (paddr == `DOPC_ADDR_OUT1);
    wire dataWr0 = apbWrite && (paddr == `DOPC_ADDR_DATA0);
    wire dataWr1 = apbWrite && (paddr == `DOPC_ADDR_DATA1);

    assign gdiff[0] = groundDiff0;
    assign gdiff[1] = groundDiff1;

    // state: supply and strap sequencing
    always @* begin
        next_state = state;
        case (state)
            ST_POWERUP: begin
                if (supplyStable) begin
                    // strap low: codes zeroed and driven at once
                    if (zeroStrap) begin
                        next_state = ST_DRIVE; // [R10] [R12]
                    end else begin
                        next_state = ST_CLAMPED; // [R13]
                    end
                end
            end
            ST_CLAMPED: begin
                if (!supplyStable) begin
                    next_state = ST_POWERUP;
                end else if (dataWritten) begin
                    next_state = ST_DRIVE; // [R2] [R17]
                end
            end
            ST_DRIVE: begin
                if (!supplyStable) begin
                    next_state = ST_POWERUP; // [R1]
                end
            end
            default: next_state = ST_POWERUP;
        endcase
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            state <= ST_POWERUP;
            dataWritten <= 1'b0;
            zeroStrap <= 1'b0;
        end else begin
            state <= next_state;
            if (state == ST_POWERUP) begin
                // straps sampled throughout power-up, last value taken
                zeroStrap <= !clear_input_n || !load_strobe_n; // [R10] [R12]
                dataWritten <= 1'b0;
            end else if (dataWr0 || dataWr1) begin
                dataWritten <= 1'b1; // [R17]
            end else if (state == ST_DRIVE) begin
                dataWritten <= 1'b0;
            end
        end
    end

    // registers
    integer i;
    always @(posedge clk) begin
        if (sys_rst) begin
            lgndEn <= 1'b0;
            gpioDir <= 2'b00;
            gpioOutVal <= 2'b00;
            for (i = 0; i < 2; i = i + 1) begin
                dataReg[i] <= `DOPC_DATA_RESET;
                rangeReg[i] <= `DOPC_RANGE_RESET; // [R14]
                fineReg[i] <= `DOPC_FINE_RESET; // [R15]
                ofsReg[i] <= `DOPC_OFS_RESET; // [R16]
            end
        end else begin
            if (state == ST_POWERUP && (!clear_input_n || !load_strobe_n)) begin
                dataReg[0] <= `DOPC_DATA_RESET; // [R10] [R12]
                dataReg[1] <= `DOPC_DATA_RESET;
            end else if (apbWrite) begin
                if (paddr == `DOPC_ADDR_CTRL) begin
                    lgndEn <= pwdata[`DOPC_CTRL_LGND];
                end else if (paddr == `DOPC_ADDR_GPIO) begin
                    gpioOutVal <= pwdata[`DOPC_GPIO_OUT_LSB +: 2]; // [R8]
                    gpioDir <= pwdata[`DOPC_GPIO_DIR_LSB +: 2]; // [R7]
                end else if (dataWr0) begin
                    dataReg[0] <= pwdata[15:0];
                end else if (dataWr1) begin
                    dataReg[1] <= pwdata[15:0];
                end else if (paddr == `DOPC_ADDR_TRIM0 || paddr == `DOPC_ADDR_TRIM1) begin
                    // range code 3 is not a documented range, kept at previous value
                    if (pwdata[`DOPC_TRIM_RANGE_LSB +: 2] != 2'h3) begin
                        rangeReg[paddr[2]] <= pwdata[`DOPC_TRIM_RANGE_LSB +: 2]; // [R6] [R14]
                    end
                    fineReg[paddr[2]] <= pwdata[`DOPC_TRIM_FINE_LSB +: 6]; // [R15]
                    ofsReg[paddr[2]] <= pwdata[`DOPC_TRIM_OFS_LSB +: 8]; // [R16]
                end
            end
        end
    end

    // code path: offset and ground shift in eighth LSB, 18-bit signed result
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : gChan
            reg [15:0] twos;
            reg [19:0] sum;
            always @* begin
                twos = coding_select ? (dataReg[ch] ^ `DOPC_BIPOLAR_FLIP) : dataReg[ch]; // [R11]
                sum = {{1{twos[15]}}, twos, 3'b000} + {{12{ofsReg[ch][7]}}, ofsReg[ch]}; // [R5]
                if (lgndEn) begin
                    sum = sum + {{4{gdiff[ch][15]}}, gdiff[ch]}; // [R9]
                end
                corrected[ch] = sum[19:2];
            end
        end
    endgenerate

    always @(posedge clk) begin
        if (sys_rst) begin
            supply_monitor_output <= 1'b0;
            amp_path_gate <= 1'b0;
            clamp_gate <= 1'b1;
            dacCode0 <= 18'h00000;
            dacCode1 <= 18'h00000;
            rangeSel0 <= `DOPC_RANGE_RESET;
            rangeSel1 <= `DOPC_RANGE_RESET;
            fineGain0 <= `DOPC_FINE_RESET;
            fineGain1 <= `DOPC_FINE_RESET;
            gpioOut <= 2'b00;
            gpioOe <= 2'b00;
            gpioPins <= 2'b00;
        end else begin
            supply_monitor_output <= supplyStable; // [R4]
            // external request overrides the sequencer at once
            if (!reset_request_input_n || state != ST_DRIVE) begin
                amp_path_gate <= 1'b0; // [R1] [R3] [R13]
                clamp_gate <= 1'b1;
            end else begin
                amp_path_gate <= 1'b1; // [R2]
                clamp_gate <= 1'b0;
            end
            dacCode0 <= corrected[0];
            dacCode1 <= corrected[1];
            rangeSel0 <= rangeReg[0]; // [R6]
            rangeSel1 <= rangeReg[1];
            fineGain0 <= fineReg[0];
            fineGain1 <= fineReg[1];
            gpioOut <= gpioOutVal; // [R7]
            gpioOe <= gpioDir;
            gpioPins <= gpioIn; // [R8]
        end
    end

    // apb answer: registered pready, one wait cycle in the access phase
    always @(posedge clk) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !valid_addr;
            if (apbRead) begin
                if (paddr == `DOPC_ADDR_CTRL) begin
                    prdata <= {31'h00000000, lgndEn};
                end else if (paddr == `DOPC_ADDR_STATUS) begin
                    prdata <= {25'h0000000, reset_request_input_n, supplyStable,
                        amp_path_gate, clamp_gate, state};
                end else if (paddr == `DOPC_ADDR_GPIO) begin
                    prdata <= {26'h0000000, gpioPins, gpioDir, gpioOutVal}; // [R8]
                end else if (paddr == `DOPC_ADDR_DATA0 || paddr == `DOPC_ADDR_DATA1) begin
                    prdata <= {16'h0000, dataReg[paddr[2]]};
                end else if (paddr == `DOPC_ADDR_TRIM0 || paddr == `DOPC_ADDR_TRIM1) begin
                    prdata <= {8'h00, ofsReg[paddr[2]], 2'b00, fineReg[paddr[2]],
                        6'h00, rangeReg[paddr[2]]};
                end else if (paddr == `DOPC_ADDR_OUT0) begin
                    prdata <= {14'h0000, dacCode0};
                end else if (paddr == `DOPC_ADDR_OUT1) begin
                    prdata <= {14'h0000, dacCode1};
                end else begin
                    prdata <= 32'h00000000;
                end
            end
        end
    end
endmodule // dopc_ctrl

// File: testbench/dopc_ctrl_chk.sv
// dopc_ctrl_chk.sv: timing checks on gates, monitor and bus answer
// assumes: one clock, sync active-high reset, bound to dopc_ctrl
module dopc_ctrl_chk (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // bus handshake
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    // supply and gates
    input wire supplyStable,
    input wire reset_request_input_n,
    input wire supply_monitor_output,
    input wire amp_path_gate,
    input wire clamp_gate
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    monitor_copy_a: assert property (
        !$past(sys_rst) |-> supply_monitor_output == $past(supplyStable))
        else $error("monitor output not a copy of detector");
    unstable_clamp_a: assert property (
        !supplyStable [*3] |-> clamp_gate && !amp_path_gate)
        else $error("outputs not clamped while supply unstable");
    request_clamp_a: assert property (
        !reset_request_input_n |=> clamp_gate && !amp_path_gate)
        else $error("reset request did not clamp");
    gate_excl_a: assert property (
        !(clamp_gate && amp_path_gate))
        else $error("clamp and amp path closed together");
    release_cause_a: assert property (
        $rose(amp_path_gate) |-> $past(supplyStable, 2))
        else $error("amp path closed without stable supply");
    ready_pulse_a: assert property (
        pready |=> !pready)
        else $error("ready longer than one cycle");
    ready_time_a: assert property (
        psel && penable && !pready |=> pready)
        else $error("ready late");
    error_ready_a: assert property (
        pslverr |-> pready)
        else $error("error without ready");
endmodule // dopc_ctrl_chk
bind dopc_ctrl dopc_ctrl_chk u_chk (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .supplyStable(supplyStable),
    .reset_request_input_n(reset_request_input_n), .clamp_gate(clamp_gate),
    .supply_monitor_output(supply_monitor_output), .amp_path_gate(amp_path_gate));

// File: testbench/dopc_host.sv
// dopc_host.sv: bus master standing in for the host controller
// assumes: bench clock, slave answers with a one-cycle pready
module dopc_host (
    // clock
    input wire logic clk,
    // bus master side
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [7:0] paddr = 8'h00,
    output logic [31:0] pwdata = 32'h00000000,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] rdata;
    logic err;
    logic tmo;
    // request held until the edge that samples pready; bounded wait
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // pready is sampled at the edge itself, before that edge's updates land
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        err = pslverr;
        tmo = (n >= 20);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // dopc_host

// File: testbench/dopc_ctrl_tb.sv
// dopc_ctrl_tb.sv: self-checking bench for the dac output control
// assumes: dopc_host drives the bus, checker bound separately
module dopc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [15:0] d; logic [7:0] o; logic cs; logic [1:0] r; logic [17:0] e;} dopc_row_t;
    dopc_row_t rows [4] = '{'{16'h0000, 8'h00, 1'b0, 2'h0, 18'h00000},
        '{16'h0000, 8'h00, 1'b1, 2'h1, 18'h30000}, '{16'h7FFF, 8'h7F, 1'b0, 2'h2, 18'h1001D},
        '{16'h0001, 8'h80, 1'b0, 2'h1, 18'h3FFE2}};
    logic clk, sys_rst = 1'b1, supplyStable = 1'b0, reset_request_input_n = 1'b1;
    logic clear_input_n = 1'b1, load_strobe_n = 1'b1, coding_select = 1'b0;
    logic [15:0] groundDiff0 = 16'h0000;
    logic [1:0] gpioIn = 2'h0, rangeSel0, gpioOut, gpioOe;
    logic psel, penable, pwrite, pready, pslverr, supply_monitor_output, amp_path_gate, clamp_gate;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [17:0] dacCode0, dacCode1;
    logic [5:0] fineGain0, fineGain1;
    logic [1:0] rangeSel1;
    int failCount = 0, totalChecks = 0;
    dopc_host host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    dopc_ctrl dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .supplyStable(supplyStable), .reset_request_input_n(reset_request_input_n),
        .clear_input_n(clear_input_n), .load_strobe_n(load_strobe_n), .coding_select(coding_select),
        .groundDiff0(groundDiff0), .groundDiff1(16'h0000), .supply_monitor_output(supply_monitor_output),
        .amp_path_gate(amp_path_gate), .clamp_gate(clamp_gate), .dacCode0(dacCode0),
        .dacCode1(dacCode1), .rangeSel0(rangeSel0), .rangeSel1(rangeSel1), .fineGain0(fineGain0),
        .fineGain1(fineGain1), .gpioIn(gpioIn),
        .gpioOut(gpioOut), .gpioOe(gpioOe));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic completeRun();
        $display("checks %0d mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            failCount++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        host.xfer(wr, a, d);
        if (host.tmo) begin
            failCount++;
            completeRun();
        end
    endtask
    // the gates only settle after the state register, so wait on them with a bound
    task automatic waitGate();
        int n;
        n = 0;
        while (amp_path_gate !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 50) begin
            failCount++;
            completeRun();
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk(clamp_gate, 1'b1);
        @(posedge clk);
        supplyStable <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk(amp_path_gate, 1'b0);
        chk(supply_monitor_output, 1'b1);
        bus(1'b1, 8'h10, 32'h00001234);
        waitGate();
        chk(clamp_gate, 1'b0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            coding_select <= rows[i].cs;
            bus(1'b1, 8'h18, {8'h00, rows[i].o, 2'h0, 6'h21, 6'h00, rows[i].r});
            bus(1'b1, 8'h10, {16'h0000, rows[i].d});
            repeat (4) @(posedge clk);
            #1;
            chk(dacCode0, rows[i].e);
            chk(rangeSel0, rows[i].r);
            chk(fineGain0, 6'h21);
        end
        bus(1'b1, 8'h18, 32'h00000003);
        repeat (3) @(posedge clk);
        #1;
        chk({rangeSel0, fineGain0}, {2'h1, 6'h00});
        // second channel: offset +1 LSB, fine -1, range 2, data 4
        bus(1'b1, 8'h1C, {8'h00, 8'h08, 2'h0, 6'h3F, 6'h00, 2'h2});
        bus(1'b1, 8'h14, 32'h00000004);
        repeat (4) @(posedge clk);
        #1;
        chk(dacCode1, 18'h0000A);
        chk({rangeSel1, fineGain1}, {2'h2, 6'h3F});
        @(posedge clk);
        groundDiff0 <= 16'h0008;
        bus(1'b1, 8'h00, 32'h00000001);
        bus(1'b1, 8'h10, 32'h00000000);
        repeat (4) @(posedge clk);
        #1;
        chk(dacCode0, 18'h00002);
        bus(1'b0, 8'h20, 32'h00000000);
        chk(host.rdata, 32'h00000002);
        bus(1'b1, 8'h00, 32'h00000000);
        @(posedge clk);
        gpioIn <= 2'b10;
        bus(1'b1, 8'h08, 32'h00000006);
        bus(1'b0, 8'h08, 32'h00000000);
        chk({gpioOe, gpioOut, host.rdata[5:0]}, {2'b01, 2'b10, 6'h26});
        bus(1'b0, 8'h0C, 32'h00000000);
        chk(host.err, 1'b1);
        @(posedge clk);
        reset_request_input_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({clamp_gate, amp_path_gate}, 2'b10);
        @(posedge clk);
        reset_request_input_n <= 1'b1;
        waitGate();
        // one pass with the clear strap low, one with the load strap low
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, 8'h10, 32'h00004000);
            @(posedge clk);
            coding_select <= k[0];
            supplyStable <= 1'b0;
            clear_input_n <= k[0];
            load_strobe_n <= !k[0];
            repeat (4) @(posedge clk);
            supplyStable <= 1'b1;
            waitGate();
            chk(dacCode0, k ? 18'h30000 : 18'h00000);
            @(posedge clk);
            clear_input_n <= 1'b1;
            load_strobe_n <= 1'b1;
        end
        completeRun();
    end
endmodule // dopc_ctrl_tb
